// ===== dv/host_reader.sv
`default_nettype none
module host_reader (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Controller status
    input wire logic busy,
    input wire logic [15:0] status_count,
    // Read result
    output logic rd_valid,
    output logic [15:0] rd_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_r;
    // The host reads only once busy drops, so it never catches a count
    // that is still advancing.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b0;
            rd_valid <= 1'b0;
            rd_count <= 16'h0000;
        end else begin
            busy_r <= busy;
            if (busy_r && !busy) begin
                rd_valid <= 1'b1;
                rd_count <= status_count;
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/self_test_seq_properties.sv
`default_nettype none
module self_test_seq_checker
    import self_test_pkg::*;
#(
    parameter int FIFO_WORDS = 16,
    parameter int BUF_DEPTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Control
    input wire logic direct_test_en,
    input wire logic verify_id_cmd,
    input wire logic [15:0] sector_reg,
    input wire logic [15:0] track_reg,
    // Status
    input wire logic busy,
    input wire logic passed,
    input wire logic failed,
    input wire logic [15:0] status_count,
    input wire logic [15:0] disk_address,
    input wire logic status_toggle,
    // FIFO and disk side
    input wire logic fifo_input_ready,
    input wire logic fifo_avail_status,
    input wire logic disk_fifo_clear,
    input wire logic fifo_bypass_direct,
    input wire logic fifo_pop_pulse,
    input wire logic drive_clock,
    input wire logic disk_start_flop,
    input wire logic latched_branch_test_bit,
    input wire logic [15:0] test_shift_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] FILL_CNT = COUNT_BASE + 16'h0004;
    localparam logic [15:0] START_CNT = COUNT_BASE + 16'h0006;
    logic [7:0] hi_cnt_r;
    logic [7:0] lo_cnt_r;
    logic [7:0] pulses_r;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    // --------------------------------------------------------------
    // Test clock phase counters.
    // --------------------------------------------------------------
    // The low count wraps in long idle spans, so it is judged only
    // between pulses of one burst.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt_r <= 8'h00;
            lo_cnt_r <= 8'h00;
            pulses_r <= 8'h00;
        end else begin
            hi_cnt_r <= drive_clock ? hi_cnt_r + 8'h01 : 8'h00;
            lo_cnt_r <= drive_clock ? 8'h00 : lo_cnt_r + 8'h01;
            if (drive_clock && hi_cnt_r == 8'h00) begin
                pulses_r <= pulses_r + 8'h01;
            end
        end
    end
    a_clear_never_on: assert property (!disk_fifo_clear)
        else $error("fifo clear active");
    a_bypass_follows: assert property (1'b1 |=>
        fifo_bypass_direct == $past(direct_test_en | verify_id_cmd))
        else $error("bypass without cause");
    a_no_pop_fill: assert property (
        status_count == FILL_CNT |-> !fifo_pop_pulse)
        else $error("pop during fill");
    a_pop_in_start: assert property (
        fifo_pop_pulse |-> status_count == START_CNT)
        else $error("pop outside start test");
    a_full_in_fill: assert property (
        $fell(fifo_input_ready) |-> status_count == FILL_CNT)
        else $error("fifo full outside fill");
    a_full_holds: assert property (
        !fifo_input_ready && fifo_avail_status && !fifo_pop_pulse
        |=> !fifo_input_ready || fifo_pop_pulse)
        else $error("input ready back without pop");
    a_count_ascends: assert property (
        $changed(status_count) && $past(status_count) != COUNT_RESET
        |-> status_count == $past(status_count) + 16'h0001)
        else $error("count did not step by one");
    a_addr_mirror: assert property ($changed(status_count)
        |-> ##[0:1] disk_address == status_count)
        else $error("disk address not the count");
    a_start_after_clk: assert property (
        $rose(disk_start_flop) |-> pulses_r != 8'h00)
        else $error("start flop set without test clock");
    a_pass_state: assert property (passed
        |-> disk_start_flop && !failed && !busy && status_count == START_CNT)
        else $error("pass with wrong state");
    a_verdict_stands: assert property (
        passed || failed |=> $stable({passed, failed, status_count}))
        else $error("verdict changed");
    a_high_phase: assert property (
        $fell(drive_clock) |-> hi_cnt_r == TCLK_PHASE_CYC)
        else $error("test clock high phase wrong");
    a_low_phase: assert property (
        $rose(drive_clock) && pulses_r != 8'h00
        |-> lo_cnt_r == TCLK_PHASE_CYC)
        else $error("test clock low phase wrong");
    c_passed: cover property ($rose(passed));
    c_full: cover property ($fell(fifo_input_ready));
    c_bypass: cover property ($rose(fifo_bypass_direct));
endmodule
bind self_test_seq self_test_seq_checker #(
    .FIFO_WORDS(FIFO_WORDS), .BUF_DEPTH(BUF_DEPTH)
) i_self_test_seq_checker (
    .ref_clk(ref_clk), .arst_n(arst_n), .direct_test_en(direct_test_en),
    .verify_id_cmd(verify_id_cmd), .sector_reg(sector_reg),
    .track_reg(track_reg), .busy(busy), .passed(passed), .failed(failed),
    .status_count(status_count), .disk_address(disk_address),
    .status_toggle(status_toggle), .fifo_input_ready(fifo_input_ready),
    .fifo_avail_status(fifo_avail_status),
    .disk_fifo_clear(disk_fifo_clear),
    .fifo_bypass_direct(fifo_bypass_direct),
    .fifo_pop_pulse(fifo_pop_pulse), .drive_clock(drive_clock),
    .disk_start_flop(disk_start_flop),
    .latched_branch_test_bit(latched_branch_test_bit),
    .test_shift_reg(test_shift_reg)
);
`default_nettype wire

// ===== dv/self_test_seq_tb.sv
`default_nettype none
module self_test_seq_tb
    import self_test_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] FILL_CNT = COUNT_BASE + 16'h0004;
    logic ref_clk, arst_n, direct_test_en, verify_id_cmd;
    logic [15:0] sector_reg, track_reg, status_count, disk_address;
    logic busy, passed, failed, status_toggle, fifo_input_ready;
    logic fifo_avail_status, disk_fifo_clear, fifo_bypass_direct;
    logic fifo_pop_pulse, drive_clock, disk_start_flop, branch_bit;
    logic [15:0] test_shift_reg, rd_count;
    logic rd_valid, pop_prev;
    logic tog_prev, clk_prev, rdy_prev, bit_seen;
    logic [15:0] cur_sec, cur_trk;
    logic [31:0] seed_r;
    int errors, total_checks, toggles, pops, rises, falls;
    self_test_seq i_self_test_seq (.ref_clk(ref_clk), .arst_n(arst_n),
        .direct_test_en(direct_test_en), .verify_id_cmd(verify_id_cmd),
        .sector_reg(sector_reg), .track_reg(track_reg), .busy(busy),
        .passed(passed), .failed(failed), .status_count(status_count),
        .disk_address(disk_address), .status_toggle(status_toggle),
        .fifo_input_ready(fifo_input_ready),
        .fifo_avail_status(fifo_avail_status),
        .disk_fifo_clear(disk_fifo_clear),
        .fifo_bypass_direct(fifo_bypass_direct),
        .fifo_pop_pulse(fifo_pop_pulse), .drive_clock(drive_clock),
        .disk_start_flop(disk_start_flop),
        .latched_branch_test_bit(branch_bit),
        .test_shift_reg(test_shift_reg));
    host_reader i_host_reader (.ref_clk(ref_clk), .arst_n(arst_n),
        .busy(busy), .status_count(status_count), .rd_valid(rd_valid),
        .rd_count(rd_count));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] exp_word(input int idx);
        logic [15:0] r8;
        r8 = (idx < 4) ? PAT_FIVES : ((idx < 8) ? PAT_AS : 16'h0000);
        case (idx % 4)
            0: return SYNC_WORD;
            1: return cur_trk;
            2: return cur_sec;
            default: return r8;
        endcase
    endfunction
    task automatic chk_v(input string what, input logic [15:0] e,
        input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_n(input string what, input int e, input int g);
        total_checks++;
        if (g != e) begin
            errors++;
            $display("ERROR %s expected %0d seen %0d", what, e, g);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // Port monitor.
    // --------------------------------------------------------------
    always @(negedge ref_clk) begin
        if (arst_n === 1'b1) begin
            if (status_toggle !== tog_prev) begin
                chk_v("count", COUNT_BASE + 16'(toggles), status_count);
                toggles++;
            end
            if (pop_prev === 1'b1) begin
                chk_v("popped word", exp_word(pops), test_shift_reg);
                pops++;
            end
            pop_prev = fifo_pop_pulse;
            if (drive_clock === 1'b1 && clk_prev === 1'b0) begin
                if (rises == 0) chk_v("start early", 16'h0000, {15'h0000, disk_start_flop});
                rises++;
            end
            if (fifo_input_ready === 1'b0 && rdy_prev === 1'b1) begin
                chk_v("count at full", FILL_CNT, status_count);
                falls++;
            end
            if (status_count === COUNT_BASE + 16'h0003 && branch_bit) begin
                bit_seen = 1'b1;
            end
            tog_prev = status_toggle;
            clk_prev = drive_clock;
            rdy_prev = fifo_input_ready;
        end
    end
    task automatic run_test(input int n, input logic [15:0] sec,
        input logic [15:0] trk, input int abort_at);
        int w;
        @(posedge ref_clk);
        arst_n <= 1'b0;
        sector_reg <= sec;
        track_reg <= trk;
        repeat (6) @(posedge ref_clk);
        {toggles, pops, rises, falls, w} = '0;
        {tog_prev, clk_prev, rdy_prev, bit_seen, pop_prev} = 5'h00;
        cur_sec = sec;
        cur_trk = trk;
        arst_n <= 1'b1;
        while (rd_valid !== 1'b1 && w < 4000) begin
            @(posedge ref_clk);
            w++;
            if (abort_at > 0 && rises >= abort_at) break;
        end
        if (abort_at == 0) begin
            chk_v("host count", COUNT_BASE + 16'h0006, rd_count);
            chk_v("verdict", 16'h0002, {14'h0000, passed, failed});
            chk_v("address", COUNT_BASE + 16'h0006, disk_address);
            chk_n("count updates", 7, toggles);
            chk_n("words popped", FIFO_DEPTH, pops);
            chk_n("test clock pulses", TCLK_PULSES, rises);
            chk_n("full events", 1, falls);
            chk_v("start flop", 16'h0001, {15'h0000, disk_start_flop});
            chk_v("branch bit", 16'h0001, {15'h0000, bit_seen});
            chk_v("fifo avail", 16'h0000, {15'h0000, fifo_avail_status});
            chk_v("input ready", 16'h0001, {15'h0000, fifo_input_ready});
            chk_v("fifo clear", 16'h0000, {15'h0000, disk_fifo_clear});
            chk_v("bypass", 16'h0000, {15'h0000, fifo_bypass_direct});
            chk_v("last word", 16'h0000, test_shift_reg);
            repeat (16) begin
                @(posedge ref_clk);
                seed_r = lfsr(seed_r);
                direct_test_en <= seed_r[0];
                verify_id_cmd <= seed_r[1];
            end
            @(posedge ref_clk);
            direct_test_en <= 1'b0;
            verify_id_cmd <= 1'b0;
        end
        $display("Test %0d done", n);
    endtask
    initial begin
        {arst_n, direct_test_en, verify_id_cmd} = 3'h0;
        {sector_reg, track_reg} = '0;
        {errors, total_checks} = '0;
        seed_r = 32'hED039FAE;
        run_test(0, 16'h0000, 16'hFFFF, 0);
        run_test(1, 16'hFFFF, 16'h0001, 5);
        for (int i = 2; i < 5; i++) begin
            seed_r = lfsr(seed_r);
            run_test(i, seed_r[15:0], seed_r[31:16], 0);
        end
        end_sim();
    end
    // A full run takes under 2000 cycles; the limit allows every run.
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        end_sim();
    end
endmodule
`default_nettype wire

// ===== rtl/self_test_pkg.sv
`default_nettype none
package self_test_pkg;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TCLK_PHASE_NS = 600;
    localparam int TCLK_PHASE_CYC = TCLK_PHASE_NS / CLK_PERIOD_NS;
    localparam int TCLK_PULSES = 24;
    localparam int SHIFT_COUNT = 16;
    localparam logic [15:0] COUNT_BASE = 16'hFF00;
    localparam logic [15:0] PAT_FIVES = 16'h5555;
    localparam logic [15:0] PAT_AS = 16'hAAAA;
    localparam logic [15:0] MSB_ONE = 16'h8000;
    localparam logic [15:0] LSB_ONE = 16'h0001;
    localparam logic [15:0] SYNC_WORD = 16'h0001;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    typedef enum logic [3:0] {
        ST_IDLE, ST_PAT5, ST_PATA, ST_ROR, ST_ROL, ST_FILL, ST_FULLCHK,
        ST_STCHK, ST_STGO, ST_STVER, ST_DONE, ST_FAIL
    } seq_t;
endpackage
`default_nettype wire

// ===== rtl/self_test_seq.sv
`default_nettype none
// Overview of operation
// - Alternating A pattern write, compare, abort on mismatch.
// - Right shift single MSB, expect shift-out exactly.
// - Two shift pulses per slice for right shift.
// - Right output feeds next left input; cross byte.
// - Shift disables carry; shift-out latches branch test bit.
// - Left shift by self-add; carry only at count.
// - Byte boundary carry feeds left byte LSB.
// - Fives in reg eight, header write pushes four.
// - Repeat complemented, cleared, push zero to fill.
// - After sixteenth word input ready stays inactive.
// - Bypass only in direct test or verify.
// - No pops, no clear while filling.
// - Start request synchronized to drive clock.
// - Start flop inactive, start, pulse, then set.
// - Test clock shifts FIFO words into test register.
// - Pass proceeds; failure aborts, count in register two.
// - Status count copied onto disk address lines.
// - Test clock 600 ns high, 600 ns low.

// ---------------------------------------------------------------------
// Small FIFO in the data path.
// ---------------------------------------------------------------------
module st_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clr,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (clr) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---------------------------------------------------------------------
// Self-test sequencer.
// ---------------------------------------------------------------------
module self_test_seq
    import self_test_pkg::*;
#(
    parameter int FIFO_WORDS = self_test_pkg::FIFO_DEPTH,
    parameter int BUF_DEPTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Control
    input wire logic direct_test_en,
    input wire logic verify_id_cmd,
    input wire logic [15:0] sector_reg,
    input wire logic [15:0] track_reg,
    // Status
    output logic busy,
    output logic passed,
    output logic failed,
    output logic [15:0] status_count,
    output logic [15:0] disk_address,
    output logic status_toggle,
    // FIFO and disk side
    output logic fifo_input_ready,
    output logic fifo_avail_status,
    output logic disk_fifo_clear,
    output logic fifo_bypass_direct,
    output logic fifo_pop_pulse,
    output logic drive_clock,
    output logic disk_start_flop,
    output logic latched_branch_test_bit,
    output logic [15:0] test_shift_reg
);
    import self_test_pkg::*;

    // -----------------------------------------------------------------
    // State and datapath.
    // -----------------------------------------------------------------
    seq_t st_r;
    logic [15:0] acc_r;
    logic [15:0] reg8_r;
    logic [15:0] cnt_r;
    logic [4:0] step_r;
    logic [1:0] phase_r;
    logic [15:0] count_r;
    logic tog_r;
    logic tbit_r;
    logic start_req_r;
    logic [2:0] start_sync_r;
    logic dstart_r;
    logic [15:0] tsr_r;
    logic [5:0] tdiv_r;
    logic tclk_r;
    logic tclk_run_r;
    logic [5:0] tpulse_r;
    logic tclk_rise;
    logic fill_valid;
    logic [15:0] fill_data;
    logic fbuf_ready;
    logic fbuf_valid;
    logic [15:0] fbuf_data;
    logic f_in_ready;
    logic f_out_valid;
    logic [15:0] f_out_data;
    logic f_pop;
    logic [4:0] fill_idx_r;

    // Right shift through byte-wide slice chain; the left byte shift-out
    // feeds the right byte MSB and the final out goes to the test bit.
    logic [15:0] shr;
    logic right_shift_final_out;
    logic left_byte_shift_out;
    logic right_byte_left_input;
    logic shift_cmd_active;
    assign left_byte_shift_out = acc_r[8];
    assign right_byte_left_input = left_byte_shift_out;
    assign right_shift_final_out = acc_r[0];
    assign shr = {1'b0, acc_r[15:9], right_byte_left_input, acc_r[7:1]};
    assign shift_cmd_active = (st_r == ST_ROR);

    // Left shift by self-add, carry rippling through byte boundary.
    logic [8:0] lo_sum;
    logic [8:0] hi_sum;
    logic byte_boundary_carry;
    assign lo_sum = {1'b0, acc_r[7:0]} + {1'b0, acc_r[7:0]};
    // A shift command blocks the carry so the shift-out alone reaches
    // the branch test bit.
    assign byte_boundary_carry = lo_sum[8] && !shift_cmd_active;
    assign hi_sum = {1'b0, acc_r[15:8]} + {1'b0, acc_r[15:8]}
        + {8'h00, byte_boundary_carry};

    // Header sequence content: sync, R3, R2, R8 for four passes.
    always_comb begin
        fill_data = 16'h0000;
        unique case (fill_idx_r[1:0])
            2'd0: fill_data = SYNC_WORD;
            2'd1: fill_data = track_reg;
            2'd2: fill_data = sector_reg;
            2'd3: fill_data = reg8_r;
        endcase
        if (fill_idx_r == 5'(FIFO_WORDS - 1)) begin
            fill_data = 16'h0000;
        end
    end
    assign fill_valid = (st_r == ST_FILL);

    // The small buffer carries header words toward the main FIFO.
    st_fifo #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clr(1'b0),
        .in_valid(fill_valid),
        .in_ready(fbuf_ready),
        .in_data(fill_data),
        .out_valid(fbuf_valid),
        .out_ready(f_in_ready),
        .out_data(fbuf_data)
    );

    st_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_WORDS)) u_fifo (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clr(1'b0),
        .in_valid(fbuf_valid),
        .in_ready(f_in_ready),
        .in_data(fbuf_data),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data(f_out_data)
    );

    // Pops happen only on test clock edges in the start test.
    assign f_pop = tclk_rise && (st_r == ST_STGO) && f_out_valid;
    assign tclk_rise = (tdiv_r == 6'(TCLK_PHASE_CYC - 1)) && !tclk_r
        && tclk_run_r;

    // -----------------------------------------------------------------
    // Test clock generator.
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tdiv_r <= '0;
            tclk_r <= 1'b0;
            tpulse_r <= '0;
        end else if (!tclk_run_r) begin
            tdiv_r <= '0;
            tclk_r <= 1'b0;
            tpulse_r <= '0;
        end else if (tdiv_r == 6'(TCLK_PHASE_CYC - 1)) begin
            tdiv_r <= '0;
            tclk_r <= !tclk_r;
            if (tclk_r) begin
                tpulse_r <= tpulse_r + 1'b1;
            end
        end else begin
            tdiv_r <= tdiv_r + 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Start flop synchronised to the drive clock.
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_sync_r <= '0;
            dstart_r <= 1'b0;
            tsr_r <= '0;
        end else begin
            if (tclk_rise) begin
                start_sync_r <= {start_sync_r[1:0], start_req_r};
                if (start_sync_r[1] && start_sync_r[2]) begin
                    dstart_r <= 1'b1;
                end
            end
            if (f_pop) begin
                tsr_r <= f_out_data;
            end
        end
    end

    // -----------------------------------------------------------------
    // Sequencer.
    // -----------------------------------------------------------------
    task automatic advance(input seq_t nxt);
        st_r <= nxt;
        count_r <= count_r + 1'b1;
        tog_r <= !tog_r;
        step_r <= '0;
        phase_r <= '0;
    endtask

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ST_IDLE;
            acc_r <= '0;
            reg8_r <= '0;
            cnt_r <= '0;
            step_r <= '0;
            phase_r <= '0;
            count_r <= COUNT_RESET;
            tog_r <= 1'b0;
            tbit_r <= 1'b0;
            start_req_r <= 1'b0;
            tclk_run_r <= 1'b0;
            fill_idx_r <= '0;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    st_r <= ST_PAT5;
                    count_r <= COUNT_BASE;
                    tog_r <= !tog_r;
                    acc_r <= PAT_FIVES;
                end
                ST_PAT5: begin
                    if (acc_r != PAT_FIVES) begin
                        st_r <= ST_FAIL;
                    end else begin
                        advance(ST_PATA);
                        acc_r <= PAT_AS;
                    end
                end
                ST_PATA: begin
                    if (acc_r != PAT_AS) begin
                        st_r <= ST_FAIL;
                    end else begin
                        advance(ST_ROR);
                        acc_r <= MSB_ONE;
                    end
                end
                ST_ROR: begin
                    // Two pulses per slice: shift on the second phase.
                    phase_r <= phase_r + 1'b1;
                    if (phase_r[0]) begin
                        acc_r <= shr;
                        tbit_r <= right_shift_final_out;
                        step_r <= step_r + 1'b1;
                        if (right_shift_final_out) begin
                            if (step_r == 5'(SHIFT_COUNT - 1)) begin
                                advance(ST_ROL);
                                acc_r <= LSB_ONE;
                                cnt_r <= 16'(SHIFT_COUNT);
                            end else begin
                                st_r <= ST_FAIL;
                            end
                        end else if (step_r == 5'(SHIFT_COUNT - 1)) begin
                            st_r <= ST_FAIL;
                        end
                    end
                end
                ST_ROL: begin
                    acc_r <= {hi_sum[7:0], lo_sum[7:0]};
                    cnt_r <= cnt_r - 1'b1;
                    if (hi_sum[8] != (cnt_r == 16'h0001)) begin
                        st_r <= ST_FAIL;
                    end else if (hi_sum[8]) begin
                        advance(ST_FILL);
                        reg8_r <= PAT_FIVES;
                        fill_idx_r <= '0;
                    end
                end
                ST_FILL: begin
                    if (fbuf_ready) begin
                        fill_idx_r <= fill_idx_r + 1'b1;
                        if (fill_idx_r == 5'd3) begin
                            reg8_r <= ~reg8_r;
                        end
                        if (fill_idx_r == 5'd7) begin
                            reg8_r <= '0;
                        end
                        if (fill_idx_r == 5'(FIFO_WORDS - 1)) begin
                            st_r <= ST_FULLCHK;
                        end
                    end
                end
                ST_FULLCHK: begin
                    if (!fbuf_valid) begin
                        if (f_in_ready) begin
                            st_r <= ST_FAIL;
                        end else begin
                            advance(ST_STCHK);
                        end
                    end
                end
                ST_STCHK: begin
                    if (dstart_r) begin
                        st_r <= ST_FAIL;
                    end else begin
                        advance(ST_STGO);
                        start_req_r <= 1'b1;
                        tclk_run_r <= 1'b1;
                    end
                end
                ST_STGO: begin
                    if (tpulse_r == 6'(TCLK_PULSES)) begin
                        tclk_run_r <= 1'b0;
                        st_r <= ST_STVER;
                    end
                end
                ST_STVER: begin
                    start_req_r <= 1'b0;
                    st_r <= dstart_r ? ST_DONE : ST_FAIL;
                end
                ST_DONE: begin
                    st_r <= ST_DONE;
                end
                ST_FAIL: begin
                    st_r <= ST_FAIL;
                    tclk_run_r <= 1'b0;
                end
                default: st_r <= ST_FAIL;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Registered outputs.
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            passed <= 1'b0;
            failed <= 1'b0;
            status_count <= COUNT_RESET;
            disk_address <= COUNT_RESET;
            status_toggle <= 1'b0;
            fifo_input_ready <= 1'b0;
            fifo_avail_status <= 1'b0;
            disk_fifo_clear <= 1'b0;
            fifo_bypass_direct <= 1'b0;
            fifo_pop_pulse <= 1'b0;
            drive_clock <= 1'b0;
            disk_start_flop <= 1'b0;
            latched_branch_test_bit <= 1'b0;
            test_shift_reg <= '0;
        end else begin
            busy <= (st_r != ST_DONE) && (st_r != ST_FAIL);
            passed <= (st_r == ST_DONE);
            failed <= (st_r == ST_FAIL);
            status_count <= count_r;
            disk_address <= count_r;
            status_toggle <= tog_r;
            fifo_input_ready <= f_in_ready;
            fifo_avail_status <= f_out_valid;
            disk_fifo_clear <= 1'b0;
            fifo_bypass_direct <= direct_test_en || verify_id_cmd;
            fifo_pop_pulse <= f_pop;
            drive_clock <= tclk_r;
            disk_start_flop <= dstart_r;
            latched_branch_test_bit <= tbit_r;
            test_shift_reg <= tsr_r;
        end
    end
endmodule
`default_nettype wire
